// ===== common/smb_pkg.sv
package smb_pkg;
  // Bit positions of the port 1 control/status register
  localparam int unsigned BIT_IS_MASTER = 7;
  localparam int unsigned BIT_TRANSMITTER = 6;
  localparam int unsigned BIT_START_REQUEST = 5;
  localparam int unsigned BIT_STOP_REQUEST = 4;
  localparam int unsigned BIT_ACK_NEEDED = 3;
  localparam int unsigned BIT_LOST_ARB = 2;
  localparam int unsigned BIT_ACK_VALUE = 1;
  localparam int unsigned BIT_IRQ = 0;
  localparam int unsigned CTRL_WIDTH = 8;

  // Reset value of the register
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Synchroniser stages and idle level of the open-drain lines
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic LINE_IDLE = 1'h1;

  // Port mode decoded from the master and transmitter bits
  typedef enum logic [3:0] {
    SMB_SLAVE_RX = 4'h1,
    SMB_SLAVE_TX = 4'h2,
    SMB_MASTER_RX = 4'h4,
    SMB_MASTER_TX = 4'h8
  } smb_mode_t;
endpackage : smb_pkg

// ===== verilog/smb_sync2.sv
`timescale 1ns/1ps
module smb_sync2 #(
  parameter logic RST_VAL = 1'h1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Asynchronous level in, synchronised level out
  input wire logic async_i,
  output logic sync_o
);
  logic meta;

  // The first stage feeds the second stage only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule : smb_sync2

// ===== verilog/smb_cond_det.sv
`timescale 1ns/1ps
module smb_cond_det (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Synchronised line levels
  input wire logic scl_i,
  input wire logic sda_i,
  // One-cycle condition pulses
  output logic start_o,
  output logic stop_o
);
  logic sda_prev;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sda_prev <= smb_pkg::LINE_IDLE;
    end else begin
      sda_prev <= sda_i;
    end
  end

  // Data may only change while the clock is low, except at a condition
  assign start_o = scl_i && sda_prev && !sda_i;
  assign stop_o = scl_i && !sda_prev && sda_i;
endmodule : smb_cond_det

// ===== verilog/smb_ctl_flags.sv
`timescale 1ns/1ps
// Operation
// - Master bit set on own START; cleared on own STOP or lost arbitration.
// - Transmitter bit set on generated START or data written before frame.
// - Transmitter cleared on detected START or no data write before frame.
// - After lost arbitration, transmitter clear waits for interrupt clear.
// - Writing 1 to start bit requests START or repeated START as master.
// - Start bit set on START plus address received; only software clears it.
// - Writing 1 to stop bit sends STOP after next ack; cleared when sent.
// - Stop bit set on STOP detected while addressed as slave.
// - Stop bit set when arbitration is lost to a detected STOP.
// - Ack-needed set on byte received, no auto ack; cleared each ack cycle.
// - Lost arbitration set on unrequested repeated START seen as master.
// - Lost arbitration on clock low while making STOP or repeated START.
// - Lost arbitration on data low while sending 1; cleared with interrupt.
// - Ack bit follows incoming ack; software writes ack or nack to send.
// - Interrupt flag set on generated START or lost arbitration.
// - Interrupt flag set after byte sent and ack or nack sampled, and after byte received.
// - Interrupt flag set on START plus address, and on STOP received while addressed.
// - While interrupt flag is set, clock line held low and bus stalled.
// - Software writes 0 to clear interrupt and advance, 1 forces interrupt.
// - With auto ack, stored ack bit is sent and ack-needed stays unused.
module smb_ctl_flags #(
  parameter int unsigned WIDTH = smb_pkg::CTRL_WIDTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Special function register port, bit-addressable through the mask
  input wire logic sfr_wr_i,
  input wire logic [WIDTH-1:0] sfr_wmask_i,
  input wire logic [WIDTH-1:0] sfr_wdata_i,
  output logic [WIDTH-1:0] sfr_rdata_o,
  // Data register write strobe from the byte register
  input wire logic serial_byte_register_wr_i,
  // Open-drain bus lines
  input wire logic port_clock_line_i,
  output logic port_clock_line_o,
  output logic port_clock_line_oe_o,
  input wire logic port_data_line_i,
  // Configuration
  input wire logic auto_ack_enable_i,
  // Events from the shifter and bit timing, one-cycle pulses except the slave_addressed_i, driving_one_i and cond_attempt_i levels
  input wire logic frame_begin_i,
  input wire logic start_generated_i,
  input wire logic stop_generated_i,
  input wire logic addr_received_i,
  input wire logic slave_addressed_i,
  input wire logic byte_sent_i,
  input wire logic byte_received_i,
  input wire logic ack_sample_i,
  input wire logic ack_cycle_done_i,
  input wire logic data_bit_sample_i,
  input wire logic driving_one_i,
  input wire logic cond_attempt_i,
  // Requests and status towards the shifter
  output logic start_request_o,
  output logic stop_request_o,
  output logic ack_send_o,
  output logic bus_stall_o,
  output logic irq_cleared_o,
  output smb_pkg::smb_mode_t mode_o,
  output logic port1_bus_event_irq_flag_o
);
  logic scl_s;
  logic sda_s;
  logic bus_start;
  logic bus_stop;

  logic port1_is_master_flag;
  logic port1_transmitter_flag;
  logic port1_start_request_flag;
  logic port1_stop_request_flag;
  logic port1_ack_needed_flag;
  logic port1_lost_arbitration_flag;
  logic port1_ack_value_bit;
  logic port1_bus_event_irq_flag;

  logic byte_written;
  logic tx_clear_pending;
  logic sw_wr_irq;
  logic sw_clr_irq;
  logic sw_set_irq;
  logic sw_wr_start;
  logic sw_wr_stop;
  logic sw_wr_ack;
  logic arb_unwanted_start;
  logic arb_clock_low;
  logic arb_data_low;
  logic arb_by_stop;
  logic arb_lost_now;
  logic tx_clear_by_start;
  logic slave_stop;
  logic ack_in_sample;
  logic irq_set_hw;
  logic [WIDTH-1:0] ctrl_word;

  // Bus lines come from another clock domain
  smb_sync2 #(
    .RST_VAL(smb_pkg::LINE_IDLE)
  ) u_sync_scl (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(port_clock_line_i),
    .sync_o(scl_s)
  );

  smb_sync2 #(
    .RST_VAL(smb_pkg::LINE_IDLE)
  ) u_sync_sda (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(port_data_line_i),
    .sync_o(sda_s)
  );

  smb_cond_det u_cond (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .start_o(bus_start),
    .stop_o(bus_stop)
  );

  // Software write decode for the interrupt bit
  assign sw_wr_irq = sfr_wr_i && sfr_wmask_i[smb_pkg::BIT_IRQ];
  assign sw_clr_irq = sw_wr_irq && !sfr_wdata_i[smb_pkg::BIT_IRQ];
  assign sw_set_irq = sw_wr_irq && sfr_wdata_i[smb_pkg::BIT_IRQ];
  // Writes change only masked bits, except an interrupt clear also clears the lost arbitration bit and, if pending, the transmitter bit
  assign sw_wr_start = sfr_wr_i && sfr_wmask_i[smb_pkg::BIT_START_REQUEST];
  assign sw_wr_stop = sfr_wr_i && sfr_wmask_i[smb_pkg::BIT_STOP_REQUEST];
  assign sw_wr_ack = sfr_wr_i && sfr_wmask_i[smb_pkg::BIT_ACK_VALUE];

  // Arbitration loss sources
  assign arb_unwanted_start = port1_is_master_flag && bus_start &&
                              !port1_start_request_flag;
  // Our own stall holds the clock low; that is no loss of arbitration
  assign arb_clock_low = port1_is_master_flag && cond_attempt_i &&
                         !scl_s && !port1_bus_event_irq_flag;
  // Ack bits are excluded: a receiver pulling data low there is normal
  assign arb_data_low = port1_is_master_flag && data_bit_sample_i &&
                        driving_one_i && !sda_s;
  // A STOP we did not ask for means another master owns the bus
  assign arb_by_stop = port1_is_master_flag && bus_stop &&
                       !port1_stop_request_flag;
  assign arb_lost_now = arb_unwanted_start || arb_clock_low ||
                        arb_data_low || arb_by_stop;

  // A START that cost us arbitration leaves the clear to the deferred path
  assign tx_clear_by_start = bus_start && !arb_lost_now;

  // A STOP only counts for us while this port is addressed
  assign slave_stop = bus_stop && slave_addressed_i;

  // Only a transmitter takes the incoming acknowledge off the line
  assign ack_in_sample = ack_sample_i && port1_transmitter_flag;

  // Hardware interrupt sources
  assign irq_set_hw = start_generated_i || arb_lost_now ||
                      (byte_sent_i && ack_sample_i) ||
                      byte_received_i ||
                      addr_received_i ||
                      slave_stop;

  // Master indicator
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port1_is_master_flag <= 1'h0;
    end else if (start_generated_i) begin
      port1_is_master_flag <= 1'h1;
    end else if (stop_generated_i || arb_lost_now) begin
      port1_is_master_flag <= 1'h0;
    end
  end

  // Tracks a data register write ahead of the next frame
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      byte_written <= 1'h0;
    end else if (serial_byte_register_wr_i) begin
      byte_written <= 1'h1;
    end else if (frame_begin_i) begin
      byte_written <= 1'h0;
    end
  end

  // Deferred transmitter clear after lost arbitration
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_clear_pending <= 1'h0;
    end else if (arb_lost_now) begin
      tx_clear_pending <= 1'h1;
    end else if (sw_clr_irq) begin
      tx_clear_pending <= 1'h0;
    end
  end

  // Transmitter indicator; sets take priority over clears
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port1_transmitter_flag <= 1'h0;
    end else if (start_generated_i) begin
      port1_transmitter_flag <= 1'h1;
    end else if (frame_begin_i && byte_written) begin
      port1_transmitter_flag <= 1'h1;
    end else if (frame_begin_i || tx_clear_by_start) begin
      port1_transmitter_flag <= 1'h0;
    end else if (tx_clear_pending && sw_clr_irq && !arb_lost_now) begin
      port1_transmitter_flag <= 1'h0;
    end
  end

  // Start bit: software request, hardware only sets it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port1_start_request_flag <= 1'h0;
    end else if (addr_received_i) begin
      port1_start_request_flag <= 1'h1;
    end else if (sw_wr_start) begin
      port1_start_request_flag <=
        sfr_wdata_i[smb_pkg::BIT_START_REQUEST];
    end
  end

  // Stop bit: request as master, detected flag as slave
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port1_stop_request_flag <= 1'h0;
    end else if (slave_stop) begin
      port1_stop_request_flag <= 1'h1;
    end else if (arb_by_stop) begin
      port1_stop_request_flag <= 1'h1;
    end else if (stop_generated_i) begin
      port1_stop_request_flag <= 1'h0;
    end else if (sw_wr_stop) begin
      port1_stop_request_flag <=
        sfr_wdata_i[smb_pkg::BIT_STOP_REQUEST];
    end
  end

  // Ack-needed flag, unused while hardware acknowledges
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port1_ack_needed_flag <= 1'h0;
    end else if (byte_received_i && !auto_ack_enable_i) begin
      port1_ack_needed_flag <= 1'h1;
    end else if (ack_cycle_done_i) begin
      port1_ack_needed_flag <= 1'h0;
    end
  end

  // Lost arbitration flag; a new loss beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port1_lost_arbitration_flag <= 1'h0;
    end else if (arb_lost_now) begin
      port1_lost_arbitration_flag <= 1'h1;
    end else if (sw_clr_irq) begin
      port1_lost_arbitration_flag <= 1'h0;
    end
  end

  // Ack bit: incoming ack is sampled on the synchronised data line
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port1_ack_value_bit <= 1'h0;
    end else if (ack_in_sample) begin
      port1_ack_value_bit <= !sda_s;
    end else if (sw_wr_ack) begin
      port1_ack_value_bit <= sfr_wdata_i[smb_pkg::BIT_ACK_VALUE];
    end
  end

  // Interrupt flag; a hardware event wins over a software clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port1_bus_event_irq_flag <= 1'h0;
    end else if (irq_set_hw || sw_set_irq) begin
      port1_bus_event_irq_flag <= 1'h1;
    end else if (sw_clr_irq) begin
      port1_bus_event_irq_flag <= 1'h0;
    end
  end

  // Advance pulse to the shifter only when the clear took effect
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_cleared_o <= 1'h0;
    end else begin
      irq_cleared_o <= sw_clr_irq && !irq_set_hw;
    end
  end

  // Register read view
  always_comb begin
    ctrl_word = smb_pkg::CTRL_RESET;
    ctrl_word[smb_pkg::BIT_IS_MASTER] = port1_is_master_flag;
    ctrl_word[smb_pkg::BIT_TRANSMITTER] = port1_transmitter_flag;
    ctrl_word[smb_pkg::BIT_START_REQUEST] = port1_start_request_flag;
    ctrl_word[smb_pkg::BIT_STOP_REQUEST] = port1_stop_request_flag;
    ctrl_word[smb_pkg::BIT_ACK_NEEDED] = port1_ack_needed_flag;
    ctrl_word[smb_pkg::BIT_LOST_ARB] = port1_lost_arbitration_flag;
    ctrl_word[smb_pkg::BIT_ACK_VALUE] = port1_ack_value_bit;
    ctrl_word[smb_pkg::BIT_IRQ] = port1_bus_event_irq_flag;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= smb_pkg::CTRL_RESET;
    end else begin
      sfr_rdata_o <= ctrl_word;
    end
  end

  // Mode decode
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_o <= smb_pkg::SMB_SLAVE_RX;
    end else begin
      case ({port1_is_master_flag, port1_transmitter_flag})
        2'h0: mode_o <= smb_pkg::SMB_SLAVE_RX;
        2'h1: mode_o <= smb_pkg::SMB_SLAVE_TX;
        2'h2: mode_o <= smb_pkg::SMB_MASTER_RX;
        2'h3: mode_o <= smb_pkg::SMB_MASTER_TX;
        default: mode_o <= smb_pkg::SMB_SLAVE_RX;
      endcase
    end
  end

  // Requests to the shifter; the stop waits for the next ack cycle there
  assign start_request_o = port1_start_request_flag;
  assign stop_request_o = port1_stop_request_flag &&
                          port1_is_master_flag;
  // Auto ack sends the stored bit; manual ack uses the same bit
  assign ack_send_o = port1_ack_value_bit;

  // Clock held low during the stall; output level is always low
  assign port_clock_line_o = 1'h0;
  assign port_clock_line_oe_o = port1_bus_event_irq_flag;
  assign bus_stall_o = port1_bus_event_irq_flag;
  assign port1_bus_event_irq_flag_o = port1_bus_event_irq_flag;
endmodule : smb_ctl_flags

// ===== tb/smb_ctl_flags_chk.sv
`timescale 1ns/1ps
module smb_ctl_flags_chk #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic sfr_wr_i,
  input wire logic [WIDTH-1:0] sfr_wmask_i,
  input wire logic [WIDTH-1:0] sfr_wdata_i,
  input wire logic [WIDTH-1:0] sfr_rdata_o,
  // Events
  input wire logic start_generated_i,
  input wire logic stop_generated_i,
  input wire logic addr_received_i,
  input wire logic byte_sent_i,
  input wire logic byte_received_i,
  input wire logic ack_sample_i,
  input wire logic ack_cycle_done_i,
  // Outputs watched
  input wire logic port_clock_line_o,
  input wire logic port_clock_line_oe_o,
  input wire logic start_request_o,
  input wire logic stop_request_o,
  input wire logic ack_send_o,
  input wire logic bus_stall_o,
  input wire logic irq_cleared_o,
  input wire smb_pkg::smb_mode_t mode_o,
  input wire logic port1_bus_event_irq_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic hw_set;
  assign hw_set = start_generated_i | (byte_sent_i & ack_sample_i) |
    byte_received_i | addr_received_i;
  chk_stall_pin: assert property (
    port_clock_line_oe_o == port1_bus_event_irq_flag_o && !port_clock_line_o
    && bus_stall_o == port1_bus_event_irq_flag_o) else $error("no stall");
  chk_irq_set: assert property (
    hw_set |=> port1_bus_event_irq_flag_o) else $error("irq not set");
  chk_irq_clear: assert property (
    port1_bus_event_irq_flag_o && sfr_wr_i && sfr_wmask_i[0] &&
    !sfr_wdata_i[0] && !hw_set |=> !port1_bus_event_irq_flag_o &&
    irq_cleared_o) else $error("irq clear failed");
  chk_start_wr: assert property (
    sfr_wr_i && sfr_wmask_i[5] && !addr_received_i |=>
    start_request_o == $past(sfr_wdata_i[5])) else $error("start write");
  chk_stop_done: assert property (
    stop_generated_i |=> !stop_request_o) else $error("stop not cleared");
  chk_ack_wr: assert property (
    sfr_wr_i && sfr_wmask_i[1] && !ack_sample_i |=>
    ack_send_o == $past(sfr_wdata_i[1])) else $error("ack write");
  chk_ackrq_clr: assert property (
    ack_cycle_done_i ##1 !byte_received_i |=> !sfr_rdata_o[3])
    else $error("ack request kept");
  chk_reset_val: assert property (
    $fell(sys_rst_i) |-> sfr_rdata_o == '0 && !bus_stall_o &&
    mode_o == smb_pkg::SMB_SLAVE_RX) else $error("bad reset state");
  cover property (irq_cleared_o);
  cover property (start_generated_i ##1 bus_stall_o);
  cover property (stop_generated_i && stop_request_o);
endmodule : smb_ctl_flags_chk

// ===== tb/smb_bus_model.sv
`timescale 1ns/1ps
module smb_bus_model (
  // Wired clock level and pull-downs of the other party
  input wire logic scl_i,
  output logic scl_pull_o,
  output logic sda_pull_o
);
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end
  // Half a link period per step; lines stand still between calls
  task automatic step(input logic c, input logic d);
    int n;
    #32;
    scl_pull_o = !c;
    sda_pull_o = !d;
    n = 0;
    while (c && !scl_i && n < 100) begin // Wait out clock stretch
      #8;
      n++;
    end
  endtask : step
  task automatic start_cond();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start_cond
  task automatic stop_cond();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop_cond
  // Back to idle without a bus condition
  task automatic idle();
    step(1'b0, 1'b0);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
  endtask : idle
endmodule : smb_bus_model

// ===== tb/smb_ctl_flags_tb_top.sv
`timescale 1ns/1ps
module smb_ctl_flags_tb_top;
  localparam int FB = 0, SG = 1, PG = 2, AR = 3, BS = 4, BR = 5, AS = 6;
  localparam int AD = 7, DB = 8, BW = 9;
  logic clk_i = 0, rst = 1, wr = 0, aa = 0, sa = 0, d1 = 0, ca = 0;
  logic [7:0] wm = 0, wd = 0, rd, m = 0;
  logic [9:0] ev = 0;
  logic scl_o, oe, stq, spq, aks, stall, ic, irq, scp, sdp;
  smb_pkg::smb_mode_t mode;
  wire logic scl_w = !(oe | scp);
  wire logic sda_w = !sdp;
  int num_errors = 0, cmp_count = 0, n;
  logic a;
  initial forever #4 clk_i = !clk_i;
  smb_bus_model bus (.scl_i(scl_w), .scl_pull_o(scp), .sda_pull_o(sdp));
  smb_ctl_flags uut (.clk_i(clk_i), .sys_rst_i(rst), .sfr_wr_i(wr),
    .sfr_wmask_i(wm), .sfr_wdata_i(wd), .sfr_rdata_o(rd),
    .serial_byte_register_wr_i(ev[BW]), .port_clock_line_i(scl_w),
    .port_clock_line_o(scl_o), .port_clock_line_oe_o(oe),
    .port_data_line_i(sda_w), .auto_ack_enable_i(aa),
    .frame_begin_i(ev[FB]), .start_generated_i(ev[SG]),
    .stop_generated_i(ev[PG]), .addr_received_i(ev[AR]),
    .slave_addressed_i(sa), .byte_sent_i(ev[BS]),
    .byte_received_i(ev[BR]), .ack_sample_i(ev[AS]),
    .ack_cycle_done_i(ev[AD]), .data_bit_sample_i(ev[DB]),
    .driving_one_i(d1), .cond_attempt_i(ca), .start_request_o(stq),
    .stop_request_o(spq), .ack_send_o(aks), .bus_stall_o(stall),
    .irq_cleared_o(ic), .mode_o(mode), .port1_bus_event_irq_flag_o(irq));
  task automatic tick(); @(posedge clk_i); #1; endtask : tick
  task automatic pulse(input int i);
    ev[i] = 1'b1;
    tick();
    ev = '0;
  endtask : pulse
  task automatic sw(input logic [7:0] k, input logic [7:0] d);
    wr = 1; wm = k; wd = d;
    tick();
    wr = 0;
    if (k[0] && !d[0] && m[2]) m[6] = 1'b0;
    if (k[0] && !d[0]) m[2] = 1'b0;
    m = (m & ~(k & 8'h33)) | (d & k & 8'h33);
  endtask : sw
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic chk(); tick(); cmp(rd, m); endtask : chk
  task automatic wait_irq();
    for (n = 0; n < 60 && irq !== 1'b1; n++) tick();
    if (irq !== 1'b1) begin
      num_errors++;
      close_out();
    end
  endtask : wait_irq
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic master();
    pulse(SG);
    m = m | 8'hc1;
    chk();
    sw(8'h01, 8'h00);
  endtask : master
  initial begin
    void'($urandom(32'hc701));
    repeat (20) tick();
    rst = 0;
    chk();
    cmp({4'h0, mode}, {4'h0, smb_pkg::SMB_SLAVE_RX});
    sw(8'h20, 8'h20);
    chk();
    pulse(SG);
    m = m | 8'hc1;
    chk();
    cmp({7'h0, oe}, 8'h01);
    cmp({4'h0, mode}, {4'h0, smb_pkg::SMB_MASTER_TX});
    sw(8'h21, 8'h00);
    chk();
    $display("test start done");
    repeat (4) begin
      a = 1'($urandom % 2);
      bus.step(1'b0, !a);
      bus.step(1'b1, !a);
      repeat (4) tick();
      ev = 10'((1 << AS) | (1 << BS));
      tick();
      ev = '0;
      m[1] = a;
      m[0] = 1'b1;
      chk();
      sw(8'h01, 8'h00);
    end
    bus.step(1'b0, 1'b1);
    bus.step(1'b1, 1'b1);
    sw(8'h10, 8'h10);
    chk();
    cmp({7'h0, spq}, 8'h01);
    pulse(PG);
    m[4] = 0;
    m[7] = 0;
    chk();
    $display("test ack and stop done");
    pulse(BR);
    m = m | 8'h09;
    chk();
    pulse(AD);
    m[3] = 0;
    chk();
    aa = 1;
    sw(8'h03, {6'h0, 1'($urandom % 2), 1'b0});
    pulse(BR);
    m[0] = 1;
    chk();
    cmp({7'h0, aks}, {7'h0, m[1]});
    sw(8'h01, 8'h00);
    aa = 0;
    pulse(FB);
    m[6] = 0;
    chk();
    pulse(BW);
    pulse(FB);
    m[6] = 1;
    chk();
    sw(8'h01, 8'h01);
    chk();
    sw(8'h01, 8'h00);
    $display("test receive done");
    master();
    d1 = 1;
    bus.step(1'b0, 1'b1);
    bus.step(1'b0, 1'b0);
    bus.step(1'b1, 1'b0);
    repeat (4) tick();
    pulse(DB);
    m = (m & 8'h7f) | 8'h05;
    chk();
    cmp({4'h0, mode}, {4'h0, smb_pkg::SMB_SLAVE_TX});
    d1 = 0;
    sw(8'h01, 8'h00);
    chk();
    bus.idle();
    master();
    ca = 1;
    bus.step(1'b0, 1'b1);
    wait_irq();
    m = (m & 8'h7f) | 8'h05;
    chk();
    ca = 0;
    sw(8'h01, 8'h00);
    chk();
    bus.step(1'b1, 1'b1);
    $display("test arbitration done");
    sa = 1;
    pulse(BW);
    pulse(FB);
    m[6] = 1;
    bus.start_cond();
    repeat (4) tick();
    pulse(AR);
    m = (m & 8'hbf) | 8'h21;
    chk();
    sw(8'h01, 8'h00);
    chk();
    bus.stop_cond();
    wait_irq();
    m = m | 8'h11;
    chk();
    sw(8'h31, 8'h00);
    sa = 0;
    master();
    bus.start_cond();
    wait_irq();
    m = (m & 8'h7f) | 8'h05;
    chk();
    sw(8'h01, 8'h00);
    chk();
    bus.idle();
    $display("test slave and restart done");
    master();
    pulse(FB);
    m[6] = 0;
    chk();
    cmp({4'h0, mode}, {4'h0, smb_pkg::SMB_MASTER_RX});
    bus.stop_cond();
    wait_irq();
    m = (m & 8'h7f) | 8'h15;
    chk();
    sw(8'h11, 8'h00);
    chk();
    $display("test stop arbitration done");
    close_out();
  end
endmodule : smb_ctl_flags_tb_top
bind smb_ctl_flags smb_ctl_flags_chk #(.WIDTH(WIDTH)) chk (.clk_i,
  .sys_rst_i, .sfr_wr_i, .sfr_wmask_i, .sfr_wdata_i, .sfr_rdata_o,
  .start_generated_i, .stop_generated_i, .addr_received_i, .byte_sent_i,
  .byte_received_i, .ack_sample_i, .ack_cycle_done_i, .port_clock_line_o,
  .port_clock_line_oe_o, .start_request_o, .stop_request_o, .ack_send_o,
  .bus_stall_o, .irq_cleared_o, .mode_o, .port1_bus_event_irq_flag_o);
